//--- hw/irq_wake_ctrl.sv
// Interrupt option register, source arbitration and WAIT/STOP control
//
// The implementer's own choice: register access over AHB-Lite.
module irq_wake_ctrl #(
    parameter logic [15:0] STAB_CYC = irq_wake_pkg::STAB_CYC_DEF
) (
    input  logic                      mclk,
    input  logic                      arst_n,
    input  logic                      hsel,
    input  logic [31:0]               haddr,
    input  logic [1:0]                htrans,
    input  logic                      hwrite,
    input  logic [2:0]                hsize,
    input  logic [31:0]               hwdata,
    input  logic                      hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  logic                      nmi_pin_n,
    input  logic                      src1_pin_n,
    input  logic                      src2_pin,
    input  irq_wake_pkg::periph_evt_s periph,
    input  irq_wake_pkg::core_req_s   core,
    input  logic                      wdog_active,
    output logic                      take_vec,
    output logic [2:0]                take_src,
    output logic                      resume,
    output logic                      halt,
    output logic                      osc_stop,
    output logic [1:0]                core_mode
);

    // Bus state
    logic [31:0] hrdata_q;
    logic        hreadyout_q;
    logic        hresp_q;
    logic        wr_pend_q;
    logic [31:0] wr_addr_q;
    logic [7:0]  opt_q;

    // Pin synchronisers and edge history
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_prev_q;

    // Request latches
    logic nmi_lat_q;
    logic nmi_lat_d;
    logic src1_lat_q;
    logic src1_lat_d;
    logic src2_lat_q;
    logic src2_lat_d;

    // Core mode tracking
    irq_wake_pkg::core_mode_e mode_q;
    irq_wake_pkg::core_mode_e mode_d;
    logic                     nmi_from_irq_q;
    logic                     nmi_from_irq_d;

    // Sleep sequencer
    irq_wake_pkg::sleep_e sleep_q;
    irq_wake_pkg::sleep_e sleep_d;
    logic [15:0]          stab_q;
    logic [15:0]          stab_d;
    logic                 wake_now;

    // Output flops
    logic       take_q;
    logic       take_d;
    logic [2:0] take_src_q;
    logic [2:0] take_src_d;
    logic       resume_q;
    logic       resume_d;
    logic       halt_q;
    logic       osc_stop_q;

    // Option fields
    logic src1_level_select;
    logic src2_edge_polarity;
    logic gen;

    assign src1_level_select = opt_q[irq_wake_pkg::OPT_LES_BIT]; // R03
    assign src2_edge_polarity = opt_q[irq_wake_pkg::OPT_ESB_BIT]; // R04
    assign gen = opt_q[irq_wake_pkg::OPT_GEN_BIT]; // R06

    // Bus decode
    logic        addr_phase;
    logic        opt_write;
    logic [31:0] stat_word;
    logic [31:0] rd_word;

    assign addr_phase = hsel & htrans[1] & hready;
    assign opt_write  = wr_pend_q & (wr_addr_q == irq_wake_pkg::OPT_ADDR);

    // Option reads give zero, status reads show live state
    assign rd_word = (haddr == irq_wake_pkg::STAT_ADDR) ? stat_word
                                                       : 32'h0000_0000; // R01

    // Address phase capture, read data ready for the data phase
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= 32'h0000_0000;
            hrdata_q    <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end
        else
        begin
            wr_pend_q   <= addr_phase & hwrite;
            wr_addr_q   <= haddr;
            hrdata_q    <= (addr_phase & ~hwrite) ? rd_word : 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end
    end

    // Option register: whole writes, unused bits dropped
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            opt_q <= irq_wake_pkg::OPT_RESET; // R02
        end
        else if (opt_write)
        begin
            opt_q <= hwdata[7:0] & irq_wake_pkg::OPT_USED_MASK; // R01 R08
        end
    end

    // Two flops per pin, third stage only for edge history
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_s1_q   <= 3'h3;
            pin_s2_q   <= 3'h3;
            pin_prev_q <= 3'h3;
        end
        else
        begin
            pin_s1_q   <= {src2_pin, src1_pin_n, nmi_pin_n};
            pin_s2_q   <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
        end
    end

    // Edge and level detection
    logic nmi_fall;
    logic src1_fall;
    logic src1_low;
    logic src2_rise;
    logic src2_fall;
    logic src2_edge;

    assign nmi_fall  = ~pin_s2_q[0] & pin_prev_q[0];
    assign src1_fall = ~pin_s2_q[1] & pin_prev_q[1];
    assign src1_low  = ~pin_s2_q[1];
    assign src2_rise = pin_s2_q[2] & ~pin_prev_q[2];
    assign src2_fall = ~pin_s2_q[2] & pin_prev_q[2];
    assign src2_edge = src2_edge_polarity ? src2_rise : src2_fall; // R05

    // Raw requests per source
    logic       req1;
    logic       req2;
    logic       req3;
    logic       req4;
    logic [4:1] mreq;
    logic       any_m;
    logic       nmi_req;

    assign req1 = src1_level_select ? src1_low : src1_lat_q; // R03
    assign req2 = src2_lat_q;

    // Shared source 3, each event behind its own mask
    assign req3 = (periph.timer1_zero_flag & periph.timer1_irq_enable)
                | (periph.lowfreq_osc_event_flag
                   & periph.lowfreq_osc_irq_enable)
                | (periph.reload_overflow_flag
                   & periph.reload_overflow_irq_enable)
                | (periph.reload_compare_flag
                   & periph.reload_compare_irq_enable)
                | (periph.reload_edge_flag
                   & periph.reload_edge_irq_enable); // R10

    assign req4 = periph.conv_done_flag & periph.conv_irq_enable; // R09

    // Global enable gates every maskable source
    assign mreq    = {req4, req3, req2, req1} & {4{gen}}; // R06 R09 R28
    assign any_m   = |mreq;
    assign nmi_req = nmi_lat_q;

    // Arbitration by fixed priority and core mode
    logic       take_nmi;
    logic       take_m;
    logic [2:0] m_sel;
    logic       boundary;
    logic       slp_cmd;
    logic       pend_en;
    logic       slp_enter;

    assign take_nmi = nmi_req & (mode_q != irq_wake_pkg::MODE_NMI); // R11
    assign take_m   = any_m & ~take_nmi
                    & (mode_q == irq_wake_pkg::MODE_NORMAL); // R11 R28

    assign m_sel = mreq[1] ? irq_wake_pkg::SRC_1 :
                   mreq[2] ? irq_wake_pkg::SRC_2 :
                   mreq[3] ? irq_wake_pkg::SRC_3 :
                             irq_wake_pkg::SRC_4; // R11

    // Sleep request is dropped while an enabled request waits
    assign slp_cmd   = (core.wait_exec | core.stop_exec)
                     & (sleep_q == irq_wake_pkg::SLP_RUN);
    assign pend_en   = nmi_req | any_m; // R26 R28
    assign slp_enter = slp_cmd & ~pend_en; // R26

    // Instruction boundaries where a vector may be taken
    assign boundary = ((core.instr_end
                        & (sleep_q == irq_wake_pkg::SLP_RUN))
                       | (slp_cmd & pend_en) | wake_now);

    // Service starts clear the matching latch
    logic clr_nmi;
    logic clr1;
    logic clr2;

    assign clr_nmi = boundary & take_nmi; // R13
    assign clr1    = boundary & take_m & (m_sel == irq_wake_pkg::SRC_1);
    assign clr2    = boundary & take_m & (m_sel == irq_wake_pkg::SRC_2);

    // Latches keep one event; a new event beats a same-cycle clear
    assign nmi_lat_d  = nmi_fall | (nmi_lat_q & ~clr_nmi); // R13
    assign src1_lat_d = ~src1_level_select & (src1_fall | (src1_lat_q & ~clr1)); // R12
    assign src2_lat_d = src2_edge | (src2_lat_q & ~clr2); // R12

    // Request latch registers
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            nmi_lat_q  <= 1'b0;
            src1_lat_q <= 1'b0;
            src2_lat_q <= 1'b0;
        end
        else
        begin
            nmi_lat_q  <= nmi_lat_d;
            src1_lat_q <= src1_lat_d;
            src2_lat_q <= src2_lat_d;
        end
    end

    // Wake sources: STOP answers only the pin-driven sources
    logic wake_any;
    logic wake_ext;

    assign wake_any = gen & (nmi_req | any_m); // R07 R25 R28
    assign wake_ext = gen & (nmi_req | mreq[1] | mreq[2]); // R16 R07 R25

    // Sleep sequencer next state
    always_comb
    begin
        sleep_d  = sleep_q;
        stab_d   = stab_q;
        wake_now = 1'b0;
        case (sleep_q)
            irq_wake_pkg::SLP_RUN:
            begin
                if (slp_enter)
                begin
                    if (core.stop_exec & ~wdog_active)
                    begin
                        sleep_d = irq_wake_pkg::SLP_STOP; // R16
                    end
                    else
                    begin
                        sleep_d = irq_wake_pkg::SLP_WAIT; // R14 R24
                    end
                end
            end
            irq_wake_pkg::SLP_WAIT:
            begin
                if (wake_any)
                begin
                    sleep_d  = irq_wake_pkg::SLP_RUN;
                    wake_now = 1'b1; // R15
                end
            end
            irq_wake_pkg::SLP_STOP:
            begin
                if (wake_ext)
                begin
                    sleep_d = irq_wake_pkg::SLP_STAB; // R17
                    stab_d  = STAB_CYC - 16'h0001; // R18
                end
            end
            irq_wake_pkg::SLP_STAB:
            begin
                if (stab_q == 16'h0000)
                begin
                    sleep_d  = irq_wake_pkg::SLP_RUN; // R17
                    wake_now = 1'b1;
                end
                else
                begin
                    stab_d = stab_q - 16'h0001; // R18
                end
            end
            default:
            begin
                sleep_d = irq_wake_pkg::SLP_RUN;
            end
        endcase
    end

    // Mode tracking: vector entry, nested NMI and return
    always_comb
    begin
        mode_d         = mode_q;
        nmi_from_irq_d = nmi_from_irq_q;
        if (boundary & take_nmi)
        begin
            mode_d         = irq_wake_pkg::MODE_NMI; // R23
            nmi_from_irq_d = (mode_q == irq_wake_pkg::MODE_IRQ); // R23
        end
        else if (boundary & take_m)
        begin
            mode_d = irq_wake_pkg::MODE_IRQ; // R20
        end
        else if (core.reti)
        begin
            case (mode_q)
                irq_wake_pkg::MODE_NMI:
                begin
                    mode_d = nmi_from_irq_q ? irq_wake_pkg::MODE_IRQ
                                            : irq_wake_pkg::MODE_NORMAL;
                    nmi_from_irq_d = 1'b0;
                end
                irq_wake_pkg::MODE_IRQ:
                begin
                    mode_d = irq_wake_pkg::MODE_NORMAL; // R22
                end
                default:
                begin
                    mode_d = irq_wake_pkg::MODE_NORMAL;
                end
            endcase
        end
    end

    // Vector strobe and source number
    assign take_d     = boundary & (take_nmi | take_m); // R11
    assign take_src_d = take_nmi ? irq_wake_pkg::SRC_NMI : m_sel;

    // Resume after wake or after a refused sleep, no vector implied
    assign resume_d = wake_now | (slp_cmd & pend_en); // R21 R22 R26

    // Sequencer, mode and output registers; reset ends any sleep
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sleep_q        <= irq_wake_pkg::SLP_RUN; // R19
            stab_q         <= 16'h0000;
            mode_q         <= irq_wake_pkg::MODE_NORMAL;
            nmi_from_irq_q <= 1'b0;
            take_q         <= 1'b0;
            take_src_q     <= 3'h0;
            resume_q       <= 1'b0;
            halt_q         <= 1'b0;
            osc_stop_q     <= 1'b0;
        end
        else
        begin
            sleep_q        <= sleep_d;
            stab_q         <= stab_d;
            mode_q         <= mode_d;
            nmi_from_irq_q <= nmi_from_irq_d;
            take_q         <= take_d;
            take_src_q     <= take_src_d;
            resume_q       <= resume_d;
            halt_q         <= (sleep_d != irq_wake_pkg::SLP_RUN); // R14
            osc_stop_q     <= (sleep_d == irq_wake_pkg::SLP_STOP); // R16
        end
    end

    // Status word: pending sources, sleep state, core mode
    logic [4:0] pend_raw;

    assign pend_raw  = {req4, req3, req2, req1, nmi_req};
    assign stat_word = (32'(pend_raw) << irq_wake_pkg::STAT_PEND_LSB)
                     | (32'(sleep_q) << irq_wake_pkg::STAT_SLEEP_LSB)
                     | (32'(mode_q) << irq_wake_pkg::STAT_MODE_LSB);

    // Outputs straight from flops; oscillator select is never touched
    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = hresp_q;
    assign take_vec  = take_q;
    assign take_src  = take_src_q;
    assign resume    = resume_q;
    assign halt      = halt_q; // R27
    assign osc_stop  = osc_stop_q;
    assign core_mode = mode_q;

endmodule

//--- hw/irq_wake_pkg.sv
// Constants, types and the overview of the interrupt option and wake block
// Overview of operation
// R01 - Option register takes whole writes only; reads return zero.
// R02 - Reset clears the option register to zero.
// R03 - Bit 6 set makes source 1 level sensitive, clear makes it edge.
// R04 - Bit 5 picks the edge polarity of source 2.
// R05 - Bit 5 one means rising edges, zero means falling edges.
// R06 - Bit 4 enables all sources; clear disables all but the NMI.
// R07 - With bit 4 clear the NMI is still served but cannot wake.
// R08 - Bit 7 and bits 3 to 0 do nothing.
// R09 - Converter done drives source 4, gated by its mask and bit 4.
// R10 - Timer, slow oscillator and reload timer events share source 3.
// R11 - NMI first, then sources 1 to 4; maskable routines never nest.
// R12 - Edge latch sets on active edge, clears at service; one is kept.
// R13 - NMI request is latched and cleared when its routine begins.
// R14 - WAIT halts instructions; clock and peripherals keep running.
// R15 - Leaving WAIT by interrupt needs no settling delay.
// R16 - STOP only without watchdog; oscillator halts until pin or reset.
// R17 - Leaving STOP waits for the oscillator before the first instruction.
// R18 - That settling wait is a fixed cycle count set by a parameter.
// R19 - A reset during WAIT or STOP ends it through the normal reset.
// R20 - From main program a wake runs the routine, then the next one.
// R21 - Inside the NMI routine any wake resumes, staying in NMI mode.
// R22 - Inside a maskable routine a maskable wake resumes that routine.
// R23 - Inside a maskable routine an NMI wake runs the NMI routine first.
// R24 - Active watchdog turns STOP into WAIT.
// R25 - With bit 4 clear nothing but reset restarts the core.
// R26 - WAIT or STOP is skipped while an enabled request is pending.
// R27 - A wake leaves the oscillator selection unchanged.
// R28 - A masked request is neither served nor blocks WAIT or STOP.
package irq_wake_pkg;

    localparam logic [31:0] OPT_ADDR      = 32'h0000_00C8;
    localparam logic [31:0] STAT_ADDR     = 32'h0000_00CC;
    localparam logic [7:0]  OPT_RESET     = 8'h00;
    localparam logic [7:0]  OPT_USED_MASK = 8'h70;
    localparam int          OPT_LES_BIT   = 6;
    localparam int          OPT_ESB_BIT   = 5;
    localparam int          OPT_GEN_BIT   = 4;
    localparam int          STAT_MODE_LSB  = 0;
    localparam int          STAT_SLEEP_LSB = 2;
    localparam int          STAT_PEND_LSB  = 4;
    localparam logic [15:0] STAB_CYC_DEF  = 16'h0400;
    localparam logic [2:0]  SRC_NMI       = 3'h0;
    localparam logic [2:0]  SRC_1         = 3'h1;
    localparam logic [2:0]  SRC_2         = 3'h2;
    localparam logic [2:0]  SRC_3         = 3'h3;
    localparam logic [2:0]  SRC_4         = 3'h4;

    typedef enum logic [1:0] {MODE_NORMAL, MODE_IRQ, MODE_NMI} core_mode_e;
    typedef enum logic [1:0] {SLP_RUN, SLP_WAIT, SLP_STOP, SLP_STAB} sleep_e;

    // Peripheral flags with their own mask bits, same clock as the block
    typedef struct packed {
        logic timer1_zero_flag;
        logic timer1_irq_enable;
        logic lowfreq_osc_event_flag;
        logic lowfreq_osc_irq_enable;
        logic reload_overflow_flag;
        logic reload_overflow_irq_enable;
        logic reload_compare_flag;
        logic reload_compare_irq_enable;
        logic reload_edge_flag;
        logic reload_edge_irq_enable;
        logic conv_done_flag;
        logic conv_irq_enable;
    } periph_evt_s;

    // Strobes from the instruction sequencer, one cycle each
    typedef struct packed {
        logic instr_end;
        logic wait_exec;
        logic stop_exec;
        logic reti;
    } core_req_s;

endpackage

//--- tb/irq_wake_chk.sv
// Port checker for the wake block
module irq_wake_chk #(
    parameter logic [15:0] STAB_CYC = irq_wake_pkg::STAB_CYC_DEF
) (
    input logic                    mclk,
    input logic                    arst_n,
    input logic                    hsel,
    input logic [31:0]             haddr,
    input logic [1:0]              htrans,
    input logic                    hwrite,
    input logic                    hready,
    input logic [31:0]             hrdata,
    input irq_wake_pkg::core_req_s core,
    input logic                    wdog_active,
    input logic                    take_vec,
    input logic [2:0]              take_src,
    input logic                    resume,
    input logic                    halt,
    input logic                    osc_stop,
    input logic [1:0]              core_mode
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    logic [15:0] cnt_q;
    logic        stop_q;

    // Settling count and STOP memory
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q  <= 16'h0000;
            stop_q <= 1'h0;
        end
        else
        begin
            cnt_q  <= osc_stop ? 16'h0000 : cnt_q + {15'h0000, halt};
            stop_q <= osc_stop | (stop_q & halt);
        end
    end

    sequence s_opt_read;
        hsel && htrans[1] && hready && !hwrite
            && haddr == irq_wake_pkg::OPT_ADDR;
    endsequence

    sequence s_take_nmi;
        take_vec && take_src == irq_wake_pkg::SRC_NMI;
    endsequence

    sequence s_take_mask;
        take_vec && take_src != irq_wake_pkg::SRC_NMI;
    endsequence

    a_opt_reads_zero: assert property (s_opt_read |=> hrdata == 32'h0)
        else $error("option read nonzero");
    a_nmi_mode: assert property (s_take_nmi |-> ##[0:1] core_mode == 2'h2)
        else $error("NMI take mode");
    a_mask_mode: assert property (s_take_mask |-> ##[0:1] core_mode == 2'h1)
        else $error("maskable take mode");
    a_no_nesting: assert property (core_mode == 2'h1 && core.instr_end
        |=> (!take_vec || take_src == irq_wake_pkg::SRC_NMI)[*2])
        else $error("maskable nesting");
    a_take_once: assert property (take_vec |=> !take_vec)
        else $error("vector pulse too long");
    a_halt_entry: assert property ($rose(halt)
        |-> $past(core.wait_exec || core.stop_exec))
        else $error("halt without sleep");
    a_stop_entry: assert property ($rose(osc_stop)
        |-> $past(core.stop_exec && !wdog_active))
        else $error("illegal oscillator stop");
    a_osc_halt: assert property (osc_stop |-> halt)
        else $error("stop without halt");
    a_wake_resume: assert property ($fell(halt) |-> resume)
        else $error("wake without resume");
    a_settle_halt: assert property ($fell(osc_stop) |-> halt)
        else $error("run before settling");
    a_settle_len: assert property ($fell(halt) && stop_q
        |-> cnt_q + 16'h0001 >= STAB_CYC && cnt_q <= STAB_CYC + 16'h0001)
        else $error("bad settling count");
endmodule

bind irq_wake_ctrl irq_wake_chk #(.STAB_CYC(STAB_CYC)) chk_u (
    .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .core(core), .wdog_active(wdog_active),
    .take_vec(take_vec), .take_src(take_src), .resume(resume),
    .halt(halt), .osc_stop(osc_stop), .core_mode(core_mode)
);

//--- tb/core_seq_model.sv
// Sequencer stand-in
module core_seq_model (
    input  logic                    halt,
    input  logic [2:0]              cmd,
    output irq_wake_pkg::core_req_s core
);
    // No instruction ends while halted
    assign core.instr_end = (cmd == 3'h1) && !halt;
    assign core.wait_exec = (cmd == 3'h2);
    assign core.stop_exec = (cmd == 3'h3);
    assign core.reti      = (cmd == 3'h4);
endmodule

//--- tb/irq_option_and_low_power_wake_bench.sv
// Self-checking bench for the wake block
module irq_option_and_low_power_wake_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] STAB = 16'h0004;
    localparam logic [31:0] NONE = 32'hFFFF_FFFF;
    localparam logic [31:0] OPT  = irq_wake_pkg::OPT_ADDR;
    logic                      mclk, arst_n, hsel, hwrite, hreadyout;
    logic [31:0]               haddr, hwdata, hrdata, rd, seed;
    logic [1:0]                htrans, core_mode;
    logic [2:0]                hsize, take_src, cmd;
    logic                      hresp, nmi_pin_n, src1_pin_n, src2_pin;
    logic                      wdog_active, take_vec, resume, halt;
    logic                      osc_stop;
    irq_wake_pkg::periph_evt_s periph;
    irq_wake_pkg::core_req_s   core;
    int                        num_errors, samples_checked, p;
    int                        expq[$];

    irq_wake_ctrl #(.STAB_CYC(STAB)) dut_u (
        .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .nmi_pin_n(nmi_pin_n),
        .src1_pin_n(src1_pin_n), .src2_pin(src2_pin), .periph(periph),
        .core(core), .wdog_active(wdog_active), .take_vec(take_vec),
        .take_src(take_src), .resume(resume), .halt(halt),
        .osc_stop(osc_stop), .core_mode(core_mode)
    );
    core_seq_model core_u (.halt(halt), .cmd(cmd), .core(core));

    // Free-running 10 MHz clock
    initial
    begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end

    // Reference arbitration
    function automatic int pick(input int pm, input int md, input int g);
        if (pm[0] && md != 2)
            return 0;
        if (md != 0 || g == 0)
            return -1;
        for (int i = 1; i < 5; i++)
            if (pm[i])
                return i;
        return -1;
    endfunction

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic chk(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== x)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask

    // One AHB-Lite transfer
    task automatic ahb(input logic [31:0] a, input logic w,
                       input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask

    // One command, then watch for a vector
    task automatic step(input logic [2:0] c, input logic [31:0] e,
                        input int lim);
        logic [31:0] g;
        g = NONE;
        cmd <= c;
        @(posedge mclk);
        #1;
        cmd <= 3'h0;
        repeat (lim)
        begin
            if (take_vec === 1'h1 && g === NONE)
                g = 32'(take_src);
            @(posedge mclk);
            #1;
        end
        chk("take_src", e, g);
    endtask

    task automatic rst();
        arst_n <= 1'h0;
        repeat (10) @(posedge mclk);
        arst_n <= 1'h1;
        @(posedge mclk);
        #1;
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        end_sim();
    end

    initial
    begin
        {hsel, hwrite, wdog_active, src2_pin} = 4'h0;
        {arst_n, nmi_pin_n, src1_pin_n} = 3'h7;
        {haddr, hwdata} = 64'h0;
        {htrans, hsize, cmd} = 8'h10;
        periph = 12'h003;
        seed = 32'hADCE8BA0;
        rst();
        step(3'h1, NONE, 4);
        ahb(OPT, 1'h1, 32'hFF);
        ahb(OPT, 1'h0, 32'h0);
        chk("opt_read", 0, rd);
        ahb(32'h0000_0010, 1'h0, 32'h0);
        chk("unmapped", 0, rd);
        step(3'h1, 4, 4);
        step(3'h4, NONE, 1);
        $display("test reset done");
        for (int k = 0; k < 24; k++)
        begin
            seed = xs(seed);
            periph <= seed[11:0];
            ahb(OPT, 1'h1, {27'h0, seed[12], 4'h0});
            p = 8 * (seed[11] & seed[10] | seed[9] & seed[8]
                | seed[7] & seed[6] | seed[5] & seed[4]
                | seed[3] & seed[2]) + 16 * (seed[1] & seed[0]);
            expq.push_back(pick(p, 0, int'(seed[12])));
            step(3'h1, expq[0], 4);
            if (expq.pop_front() != -1)
            begin
                step(3'h1, NONE, 4);
                step(3'h4, NONE, 1);
            end
        end
        $display("test random done");
        periph <= 12'h000;
        ahb(OPT, 1'h1, 32'h00);
        nmi_pin_n <= 1'h0;
        step(3'h0, NONE, 4);
        step(3'h1, 0, 4);
        chk("mode", 2, 32'(core_mode));
        step(3'h4, NONE, 1);
        step(3'h1, NONE, 4);
        nmi_pin_n <= 1'h1;
        periph <= 12'h003;
        step(3'h2, NONE, 2);
        chk("halt", 1, 32'(halt));
        nmi_pin_n <= 1'h0;
        step(3'h0, NONE, 8);
        chk("halt", 1, 32'(halt));
        nmi_pin_n <= 1'h1;
        rst();
        chk("halt", 0, 32'(halt));
        ahb(OPT, 1'h1, 32'h10);
        periph <= 12'h000;
        step(3'h2, NONE, 2);
        chk("osc_stop", 0, 32'(osc_stop));
        periph <= 12'h003;
        step(3'h0, 4, 3);
        step(3'h4, NONE, 1);
        step(3'h2, 4, 3);
        chk("halt", 0, 32'(halt));
        step(3'h4, NONE, 1);
        $display("test wait done");
        ahb(OPT, 1'h1, 32'h30);
        periph <= 12'h000;
        step(3'h3, NONE, 2);
        chk("osc_stop", 1, 32'(osc_stop));
        periph <= 12'h003;
        step(3'h0, NONE, 6);
        src2_pin <= 1'h1;
        step(3'h0, 2, 20);
        step(3'h4, NONE, 1);
        src2_pin <= 1'h0;
        wdog_active <= 1'h1;
        periph <= 12'h000;
        step(3'h3, NONE, 2);
        chk("osc_stop", 0, 32'(osc_stop));
        chk("halt", 1, 32'(halt));
        nmi_pin_n <= 1'h0;
        step(3'h0, 0, 6);
        step(3'h2, NONE, 2);
        periph <= 12'h003;
        step(3'h0, NONE, 3);
        chk("mode", 2, 32'(core_mode));
        step(3'h4, NONE, 1);
        nmi_pin_n <= 1'h1;
        step(3'h1, 4, 4);
        periph <= 12'h000;
        step(3'h2, NONE, 2);
        nmi_pin_n <= 1'h0;
        step(3'h0, 0, 6);
        step(3'h4, NONE, 1);
        chk("mode", 1, 32'(core_mode));
        step(3'h4, NONE, 1);
        {wdog_active, nmi_pin_n} <= 2'h1;
        $display("test stop done");
        ahb(OPT, 1'h1, 32'h50);
        src1_pin_n <= 1'h0;
        step(3'h0, NONE, 4);
        step(3'h1, 1, 4);
        step(3'h4, NONE, 1);
        step(3'h1, 1, 4);
        ahb(OPT, 1'h1, 32'h10);
        for (int k = 0; k < 4; k++)
        begin
            src1_pin_n <= ~k[0];
            step(3'h1, NONE, 4);
        end
        step(3'h4, NONE, 1);
        step(3'h1, 1, 4);
        step(3'h4, NONE, 1);
        step(3'h1, NONE, 4);
        src1_pin_n <= 1'h1;
        src2_pin <= 1'h1;
        step(3'h0, NONE, 4);
        step(3'h1, NONE, 4);
        src2_pin <= 1'h0;
        step(3'h0, NONE, 4);
        step(3'h1, 2, 4);
        step(3'h4, NONE, 1);
        $display("test pins done");
        end_sim();
    end
endmodule
